// ===== iwp_consts.svh
`ifndef IWP_CONSTS_SVH
`define IWP_CONSTS_SVH

// register byte offsets
`define IWP_OFS_CONTROL    6'h00
`define IWP_OFS_LP_STOP    6'h04
`define IWP_OFS_REFRESH    6'h08
`define IWP_OFS_STATUS     6'h0C
`define IWP_OFS_IRQ_STAT   6'h10
`define IWP_OFS_IRQ_MASK   6'h14

// field positions
`define IWP_PSEL_LSB       0
`define IWP_PSEL_MSB       1
`define IWP_SLCSTOP_BIT    0
`define IWP_IRQ_TIMEOUT    0
`define IWP_STAT_CNT_LSB   0
`define IWP_STAT_ST_LSB    16

// reset values
`define IWP_PSEL_RST       2'h3
`define IWP_STOP_RST       1'h0
`define IWP_MASK_RST       1'h0

// counter start values, cycle count minus one
`define IWP_FAST_P0        14'h03FF
`define IWP_FAST_P1        14'h0FFF
`define IWP_FAST_P2        14'h1FFF
`define IWP_FAST_P3        14'h3FFF
`define IWP_SLOW_P0        14'h007F
`define IWP_SLOW_P1        14'h01FF
`define IWP_SLOW_P2        14'h03FF
`define IWP_SLOW_P3        14'h07FF

`endif

// ===== iwp_down_counter.sv
`timescale 1ns/1ns
`default_nettype none

module iwp_down_counter
  import iwp_pkg::*;
#(
  parameter int unsigned W = 14
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  input  wire logic         dec,
  output logic      [W-1:0] count,
  output logic              at_zero
);

  logic [W-1:0] count_ff;

  // load has priority over decrement
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count_ff <= '0;
    end else if (clk_en) begin
      if (load) begin
        count_ff <= load_value;
      end else if (dec && (count_ff != '0)) begin
        count_ff <= count_ff - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign count   = count_ff;
  assign at_zero = (count_ff == '0);

endmodule

`default_nettype wire

// ===== iwp_pkg.sv
`default_nettype none

package iwp_pkg;

  // one-hot watchdog states
  typedef enum logic [3:0] {
    IWP_ST_IDLE    = 4'b0001,
    IWP_ST_RUN     = 4'b0010,
    IWP_ST_HALT    = 4'b0100,
    IWP_ST_EXPIRED = 4'b1000
  } iwp_state_t;

  typedef logic [1:0] iwp_psel_t;

endpackage

`default_nettype wire

// ===== iwp_sync2.sv
`timescale 1ns/1ns
`default_nettype none

module iwp_sync2
  import iwp_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // two stages; only the second stage is visible outside
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

`default_nettype wire

// ===== iwp_watchdog.sv
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "iwp_consts.svh"

module iwp_watchdog
  import iwp_pkg::*;
#(
  parameter int unsigned SLOW_VARIANT = 0,
  parameter int unsigned CNT_W        = 14,
  parameter int unsigned ADDR_W       = 6
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              watchdog_count_clock,
  input  wire logic              sleep_mode_req,
  input  wire logic              sw_standby_req,
  input  wire logic              deep_stop_req,
  output logic                   timeout_event,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  iwp_state_t        state_ff;
  iwp_state_t        nxt_state;
  iwp_psel_t         psel_ff;
  logic              stop_ctl_ff;
  logic              irq_stat_ff;
  logic              irq_mask_ff;
  logic              irq_ff;
  logic              timeout_ff;
  logic              waitreq_ff;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic              cclk_prev_ff;
  logic [3:0]        pins_s;
  logic              cclk_s;
  logic              lp_any_s;
  logic              tick;
  logic              lp_stop;
  logic              bus_acc;
  logic              wr_acc;
  logic              rd_acc;
  logic              refresh_wr;
  logic              cnt_load;
  logic              cnt_dec;
  logic              expire;
  logic [CNT_W-1:0]  cnt;
  logic              cnt_zero;
  logic [CNT_W-1:0]  start_val;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // period code to counter start value, per variant
  function automatic logic [CNT_W-1:0] start_of(input iwp_psel_t code);
    logic [13:0] v;
    v = `IWP_FAST_P3;
    if (SLOW_VARIANT != 0) begin
      case (code)
        2'h0:    v = `IWP_SLOW_P0;
        2'h1:    v = `IWP_SLOW_P1;
        2'h2:    v = `IWP_SLOW_P2;
        default: v = `IWP_SLOW_P3;
      endcase
    end else begin
      case (code)
        2'h0:    v = `IWP_FAST_P0;
        2'h1:    v = `IWP_FAST_P1;
        2'h2:    v = `IWP_FAST_P2;
        default: v = `IWP_FAST_P3;
      endcase
    end
    return v[CNT_W-1:0];
  endfunction

  // register hit at a byte offset, word aligned
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
    return (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and count-clock edge

  iwp_sync2 #(
    .W (4)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .async_in ({deep_stop_req, sw_standby_req, sleep_mode_req, watchdog_count_clock}),
    .sync_out (pins_s)
  );

  assign cclk_s   = pins_s[0];
  assign lp_any_s = pins_s[1] | pins_s[2] | pins_s[3];

  // previous sample taken from the synchronised copy only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cclk_prev_ff <= 1'b0;
    end else if (clk_en) begin
      cclk_prev_ff <= cclk_s;
    end
  end

  // count clock must be well below sys_clk so no edge is missed
  assign tick = cclk_s & ~cclk_prev_ff;

  // stop only when software opted in and a low-power mode is entered
  assign lp_stop = stop_ctl_ff & lp_any_s;

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave handshake

  assign bus_acc    = (avs_read | avs_write) & ~waitreq_ff;
  assign wr_acc     = avs_write & ~waitreq_ff;
  assign rd_acc     = avs_read & ~waitreq_ff;
  assign refresh_wr = wr_acc & hit(avs_address, `IWP_OFS_REFRESH) & avs_byteenable[0];

  // one wait cycle per access, then waitrequest low for exactly one edge
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      waitreq_ff <= 1'b1;
    end else if (clk_en) begin
      waitreq_ff <= ~((avs_read | avs_write) & waitreq_ff);
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit(avs_address, `IWP_OFS_CONTROL)) begin
      nxt_rdata[`IWP_PSEL_MSB:`IWP_PSEL_LSB] = psel_ff;
    end else if (hit(avs_address, `IWP_OFS_LP_STOP)) begin
      nxt_rdata[`IWP_SLCSTOP_BIT] = stop_ctl_ff;
    end else if (hit(avs_address, `IWP_OFS_STATUS)) begin
      nxt_rdata[`IWP_STAT_CNT_LSB +: CNT_W] = cnt;
      nxt_rdata[`IWP_STAT_ST_LSB +: 4]      = state_ff;
    end else if (hit(avs_address, `IWP_OFS_IRQ_STAT)) begin
      nxt_rdata[`IWP_IRQ_TIMEOUT] = irq_stat_ff;
    end else if (hit(avs_address, `IWP_OFS_IRQ_MASK)) begin
      nxt_rdata[`IWP_IRQ_TIMEOUT] = irq_mask_ff;
    end
  end

  // data captured as waitrequest falls, so it stands at the answer edge
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      if (avs_read && waitreq_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = waitreq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // period select, used at the next reload
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      psel_ff <= `IWP_PSEL_RST;
    end else if (clk_en) begin
      if (wr_acc && hit(avs_address, `IWP_OFS_CONTROL) && avs_byteenable[0]) begin
        psel_ff <= avs_writedata[`IWP_PSEL_MSB:`IWP_PSEL_LSB];
      end
    end
  end

  // low-power count stop control
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stop_ctl_ff <= `IWP_STOP_RST;
    end else if (clk_en) begin
      if (wr_acc && hit(avs_address, `IWP_OFS_LP_STOP) && avs_byteenable[0]) begin
        stop_ctl_ff <= avs_writedata[`IWP_SLCSTOP_BIT];
      end
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_mask_ff <= `IWP_MASK_RST;
    end else if (clk_en) begin
      if (wr_acc && hit(avs_address, `IWP_OFS_IRQ_MASK) && avs_byteenable[0]) begin
        irq_mask_ff <= avs_writedata[`IWP_IRQ_TIMEOUT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter

  assign start_val = start_of(psel_ff);
  assign cnt_load  = refresh_wr;
  assign cnt_dec   = tick & (state_ff == IWP_ST_RUN) & ~lp_stop & ~refresh_wr;
  // expiry on the tick after zero: start value plus one ticks in all
  assign expire    = cnt_dec & cnt_zero;

  iwp_down_counter #(
    .W (CNT_W)
  ) u_cnt (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .clk_en     (clk_en),
    .load       (cnt_load),
    .load_value (start_val),
    .dec        (cnt_dec),
    .count      (cnt),
    .at_zero    (cnt_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IWP_ST_IDLE: begin
        if (refresh_wr) begin
          nxt_state = IWP_ST_RUN;
        end
      end
      IWP_ST_RUN: begin
        if (expire) begin
          nxt_state = IWP_ST_EXPIRED;
        end else if (lp_stop) begin
          nxt_state = IWP_ST_HALT;
        end
      end
      IWP_ST_HALT: begin
        if (!lp_stop) begin
          nxt_state = IWP_ST_RUN;
        end
      end
      IWP_ST_EXPIRED: begin
        if (refresh_wr) begin
          nxt_state = IWP_ST_RUN;
        end
      end
      default: nxt_state = IWP_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_ff <= IWP_ST_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout event and interrupt

  // one-cycle pulse to reset or interrupt logic
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      timeout_ff <= 1'b0;
    end else if (clk_en) begin
      timeout_ff <= expire;
    end
  end

  // sticky; a new expiry wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_stat_ff <= 1'b0;
    end else if (clk_en) begin
      if (expire) begin
        irq_stat_ff <= 1'b1;
      end else if (wr_acc && hit(avs_address, `IWP_OFS_IRQ_STAT) && avs_byteenable[0]
                   && avs_writedata[`IWP_IRQ_TIMEOUT]) begin
        irq_stat_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      irq_ff <= irq_stat_ff & irq_mask_ff;
    end
  end

  assign timeout_event = timeout_ff;
  assign irq           = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_fast_periods: assert property (@(posedge sys_clk) disable iff (!rstn)
    (SLOW_VARIANT == 0) |-> ((psel_ff == 2'h0) ? start_val == 14'h03FF :
                             (psel_ff == 2'h1) ? start_val == 14'h0FFF :
                             (psel_ff == 2'h2) ? start_val == 14'h1FFF :
                                                 start_val == 14'h3FFF))
    else $error("fast variant start value wrong");

  a_slow_periods: assert property (@(posedge sys_clk) disable iff (!rstn)
    (SLOW_VARIANT != 0) |-> ((psel_ff == 2'h0) ? start_val == 14'h007F :
                             (psel_ff == 2'h1) ? start_val == 14'h01FF :
                             (psel_ff == 2'h2) ? start_val == 14'h03FF :
                                                 start_val == 14'h07FF))
    else $error("slow variant start value wrong");

  a_reload_value: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && refresh_wr) |=> (cnt == $past(start_val)))
    else $error("refresh did not load the period start value");

  a_count_runs: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && tick && !stop_ctl_ff && state_ff == IWP_ST_RUN && !refresh_wr && !cnt_zero)
    |=> (cnt == $past(cnt) - 14'h0001))
    else $error("counter did not count with stop control clear");

  a_sleep_halts: assert property (@(posedge sys_clk) disable iff (!rstn)
    (stop_ctl_ff && (pins_s[1] || pins_s[2]) && !refresh_wr) |=> $stable(cnt))
    else $error("counter moved in sleep or standby with stop set");

  a_deep_halts: assert property (@(posedge sys_clk) disable iff (!rstn)
    (stop_ctl_ff && pins_s[3] && state_ff == IWP_ST_RUN && clk_en)
    |=> (state_ff == IWP_ST_HALT || state_ff == IWP_ST_EXPIRED) && !timeout_ff)
    else $error("counter not halted in clock-stop or deep sleep");

  a_timeout_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_ff == IWP_ST_RUN && tick && cnt_zero && !lp_stop && !refresh_wr)
    |=> timeout_ff && state_ff == IWP_ST_EXPIRED ##1 !timeout_ff || !clk_en)
    else $error("expiry did not raise a single timeout pulse");

  a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && timeout_ff && irq_mask_ff) |=> ##[0:2] irq)
    else $error("unmasked timeout did not raise irq");

  a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && (avs_read || avs_write) && waitreq_ff) |=> !avs_waitrequest)
    else $error("slave did not answer in one cycle");

endmodule

`default_nettype wire

// ===== iwp_watchdog_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "iwp_consts.svh"

module iwp_watchdog_tb
  import iwp_pkg::*;
;
  typedef struct packed {
    logic [1:0]  code;
    logic [13:0] fast;
    logic [13:0] slow;
  } iwp_row_t;

  logic        sys_clk;
  logic        rstn;
  logic        clk_en;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic        count_clk;
  logic [2:0]  lp_req;
  logic [31:0] rdata_f;
  logic [31:0] rdata_s;
  logic        wreq_f;
  logic        wreq_s;
  logic        tev_f;
  logic        tev_s;
  logic        irq_f;
  logic        irq_s;
  logic [31:0] rd_f;
  logic [31:0] rd_s;
  logic [13:0] exp_f;
  logic [13:0] exp_s;
  int          miscompares;
  int          total_checks;
  int          to_f;
  int          to_s;
  int          cyc;
  iwp_row_t    rows [4];

  ////////////////////////////////////////////////////////////////////////////
  // both variants share every input, so one stimulus covers both tables
  iwp_watchdog #(.SLOW_VARIANT(0)) iwp_watchdog_i (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(rdata_f),
    .avs_waitrequest(wreq_f), .watchdog_count_clock(count_clk),
    .sleep_mode_req(lp_req[0]), .sw_standby_req(lp_req[1]),
    .deep_stop_req(lp_req[2]), .timeout_event(tev_f), .irq(irq_f));

  iwp_watchdog #(.SLOW_VARIANT(1)) iwp_watchdog_slow_i (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(rdata_s),
    .avs_waitrequest(wreq_s), .watchdog_count_clock(count_clk),
    .sleep_mode_req(lp_req[0]), .sw_standby_req(lp_req[1]),
    .deep_stop_req(lp_req[2]), .timeout_event(tev_s), .irq(irq_s));

  ////////////////////////////////////////////////////////////////////////////
  // clock, pulse counters and the hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (tev_f === 1'b1) to_f++;
    if (tev_s === 1'b1) to_s++;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge sys_clk);
      cyc++;
      if (cyc == 30000) begin
        miscompares++;
        $display("Error run_time expected below 30000 seen 30000");
        finish_test();
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // avalon cycle: hold until waitrequest samples low, take data at that edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (wreq_f !== 1'b0);
    rd_f = rdata_f;
    rd_s = rdata_s;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // count clock kept at 3 high, 3 low so the synchroniser never misses a phase
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      count_clk <= 1'b1;
      repeat (3) @(posedge sys_clk);
      count_clk <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
  endtask

  function automatic logic [31:0] st(input logic [3:0] s, input logic [13:0] c);
    return {12'h000, s, 2'b00, c};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{2'h0, 14'h03FF, 14'h007F};
    rows[1] = '{2'h1, 14'h0FFF, 14'h01FF};
    rows[2] = '{2'h2, 14'h1FFF, 14'h03FF};
    rows[3] = '{2'h3, 14'h3FFF, 14'h07FF};
    miscompares = 0;
    total_checks = 0;
    rstn = 1'b0;
    clk_en = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    count_clk = 1'b0;
    lp_req = 3'b000;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    // reset values, an unmapped word that ignores writes
    bus(1'b0, `IWP_OFS_CONTROL, 32'h0);
    chk("control", 32'h0000_0003, rd_f);
    bus(1'b0, `IWP_OFS_LP_STOP, 32'h0);
    chk("lp_stop", 32'h0000_0000, rd_f);
    bus(1'b0, `IWP_OFS_STATUS, 32'h0);
    chk("status", st(IWP_ST_IDLE, 14'h0000), rd_f);
    bus(1'b1, 6'h18, 32'hFFFF_FFFF);
    bus(1'b0, 6'h18, 32'h0);
    chk("unmapped", 32'h0000_0000, rd_f);
    chk("irq", 32'h0000_0000, {30'h0, irq_f, irq_s});
    $display("test reset done");
    // each period code loads its start value in both variants
    foreach (rows[i]) begin
      bus(1'b1, `IWP_OFS_CONTROL, {30'h0, rows[i].code});
      bus(1'b1, `IWP_OFS_REFRESH, 32'h0000_0001);
      bus(1'b0, `IWP_OFS_STATUS, 32'h0);
      chk("fast_start", st(IWP_ST_RUN, rows[i].fast), rd_f);
      chk("slow_start", st(IWP_ST_RUN, rows[i].slow), rd_s);
    end
    $display("test periods done");
    // stop bit clear: every low-power request leaves the count running
    bus(1'b1, `IWP_OFS_CONTROL, 32'h0000_0000);
    bus(1'b1, `IWP_OFS_REFRESH, 32'h0000_0001);
    lp_req <= 3'b111;
    tick(5);
    bus(1'b0, `IWP_OFS_STATUS, 32'h0);
    exp_f = 14'h03FF - 14'd5;
    exp_s = 14'h007F - 14'd5;
    chk("fast_lp_run", st(IWP_ST_RUN, exp_f), rd_f);
    chk("slow_lp_run", st(IWP_ST_RUN, exp_s), rd_s);
    lp_req <= 3'b000;
    bus(1'b1, `IWP_OFS_LP_STOP, 32'h0000_0001);
    // stop bit set: each request alone halts, release resumes
    for (int r = 0; r < 3; r++) begin
      lp_req <= 3'b001 << r;
      tick(4);
      bus(1'b0, `IWP_OFS_STATUS, 32'h0);
      chk("fast_halt", st(IWP_ST_HALT, exp_f), rd_f);
      chk("slow_halt", st(IWP_ST_HALT, exp_s), rd_s);
      lp_req <= 3'b000;
      tick(1);
      exp_f = exp_f - 14'd1;
      exp_s = exp_s - 14'd1;
      bus(1'b0, `IWP_OFS_STATUS, 32'h0);
      chk("fast_resume", st(IWP_ST_RUN, exp_f), rd_f);
      chk("slow_resume", st(IWP_ST_RUN, exp_s), rd_s);
    end
    $display("test low power done");
    // full shortest periods: expiry after exactly 128 and 1024 ticks
    bus(1'b1, `IWP_OFS_LP_STOP, 32'h0000_0000);
    bus(1'b1, `IWP_OFS_IRQ_MASK, 32'h0000_0001);
    bus(1'b1, `IWP_OFS_REFRESH, 32'h0000_0001);
    to_f = 0;
    to_s = 0;
    tick(127);
    chk("slow_early", 32'd0, to_s);
    tick(1);
    chk("slow_expiry", 32'd1, to_s);
    chk("slow_irq", 32'h0000_0001, {31'h0, irq_s});
    bus(1'b0, `IWP_OFS_STATUS, 32'h0);
    chk("slow_state", st(IWP_ST_EXPIRED, 14'h0000), rd_s);
    tick(895);
    chk("fast_early", 32'd0, to_f);
    tick(1);
    chk("fast_expiry", 32'd1, to_f);
    chk("no_reload", 32'd1, to_s);
    // masking drops the line, write one clears the sticky bit
    bus(1'b1, `IWP_OFS_IRQ_MASK, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    chk("irq_masked", 32'h0000_0000, {30'h0, irq_f, irq_s});
    bus(1'b0, `IWP_OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", 32'h0000_0001, rd_f);
    bus(1'b1, `IWP_OFS_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    chk("irq_unmasked", 32'h0000_0003, {30'h0, irq_f, irq_s});
    bus(1'b1, `IWP_OFS_IRQ_STAT, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    chk("irq_cleared", 32'h0000_0000, {30'h0, irq_f, irq_s});
    $display("test expiry done");
    // reset after expiry returns the idle state
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(1'b0, `IWP_OFS_STATUS, 32'h0);
    chk("status_rerst", st(IWP_ST_IDLE, 14'h0000), rd_f);
    $display("test second reset done");
    // enable low freezes the synchroniser too, so pulses in that time are lost
    bus(1'b1, `IWP_OFS_REFRESH, 32'h0000_0001);
    clk_en <= 1'b0;
    tick(3);
    clk_en <= 1'b1;
    bus(1'b0, `IWP_OFS_STATUS, 32'h0);
    chk("fast_frozen", st(IWP_ST_RUN, 14'h3FFF), rd_f);
    chk("slow_frozen", st(IWP_ST_RUN, 14'h07FF), rd_s);
    tick(1);
    bus(1'b0, `IWP_OFS_STATUS, 32'h0);
    chk("fast_thawed", st(IWP_ST_RUN, 14'h3FFE), rd_f);
    chk("slow_thawed", st(IWP_ST_RUN, 14'h07FE), rd_s);
    $display("test clock enable done");
    finish_test();
  end
endmodule

`default_nettype wire
